// File: sas_sequencer.sv
// Successive-approximation converter sequencer with APB register slave.
// Assumes an external sample-and-hold, comparator and tapped ladder; the
// comparator answer arrives asynchronously, standby levels are on pclk.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

module sas_sequencer (
    input wire logic pclk, // APB and converter clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic [31:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic ext_trigger_in, // External trigger pin
    input wire logic comp_above_in, // Comparator: input at or above tap
    input wire logic standby_idle, // Device in idle standby
    input wire logic standby_stop, // Device in stop standby
    output logic [3:0] analog_sel, // Selected analog input
    output logic ladder_connect, // Ladder tied to reference supply
    output logic comparator_power_down, // Comparator switched off
    output logic sample_hold, // Sample-and-hold tracking
    output logic [9:0] ladder_tap, // Trial code on the ladder
    output logic conv_done_irq // Conversion done pulse
);

    // Byte address of a register index
    function automatic logic [31:0] reg_addr(input logic [31:0] idx);
        reg_addr = {idx[29:0], 2'b00};
    endfunction : reg_addr

    // One-hot trial mask for an approximation bit
    function automatic logic [9:0] trial_mask(input logic [3:0] idx);
        trial_mask = 10'h001 << idx;
    endfunction : trial_mask

    // Cycles per approximation slot for a rate code
    function automatic logic [7:0] slot_len(input logic [2:0] fr);
        int c;
        c = sas_pkg::SAS_CONV_FR0;
        unique case (fr)
            3'd0: c = sas_pkg::SAS_CONV_FR0;
            3'd1: c = sas_pkg::SAS_CONV_FR1;
            3'd2: c = sas_pkg::SAS_CONV_FR2;
            3'd3: c = sas_pkg::SAS_CONV_FR3;
            3'd4: c = sas_pkg::SAS_CONV_FR4;
            3'd5: c = sas_pkg::SAS_CONV_FR5;
            3'd6: c = sas_pkg::SAS_CONV_FR0;
            3'd7: c = sas_pkg::SAS_CONV_FR7;
        endcase
        slot_len = 8'(c / sas_pkg::SAS_SLOTS);
    endfunction : slot_len

    // Stabilisation cycles for a rate code
    function automatic logic [7:0] stab_len(input logic [2:0] fr);
        int c;
        c = sas_pkg::SAS_STAB_FR0;
        unique case (fr)
            3'd0: c = sas_pkg::SAS_STAB_FR0;
            3'd1: c = sas_pkg::SAS_STAB_FR1;
            3'd2: c = sas_pkg::SAS_STAB_FR2;
            3'd3: c = sas_pkg::SAS_STAB_FR3;
            3'd4: c = sas_pkg::SAS_STAB_FR4;
            3'd5: c = sas_pkg::SAS_STAB_FR5;
            3'd6: c = sas_pkg::SAS_STAB_FR0;
            3'd7: c = sas_pkg::SAS_STAB_FR7;
        endcase
        stab_len = 8'(c);
    endfunction : stab_len

    logic [7:0] mode_q;
    logic [3:0] chan_q;
    logic ladder_q;
    logic [9:0] result_q;
    logic [9:0] pend_val_q;
    logic pend_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    logic comp_s1_q, comp_s2_q;
    sas_pkg::sas_state_t state_q;
    logic [7:0] cnt_q;
    logic [3:0] bit_q;
    logic [9:0] sar_q;
    logic irq_q;
    logic pd_q;
    logic sh_q;

    // Bus decode
    logic setup, wr_acc, wr_mode, wr_chan, wr_ladder, rd_result;
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_q & pwrite;
    assign wr_mode = wr_acc & (paddr == reg_addr(sas_pkg::SAS_IDX_MODE1));
    assign wr_chan = wr_acc & (paddr == reg_addr(sas_pkg::SAS_IDX_CHAN));
    assign wr_ladder = wr_acc & (paddr == reg_addr(sas_pkg::SAS_IDX_LADDER));
    assign rd_result = setup & ~pwrite
        & (paddr == reg_addr(sas_pkg::SAS_IDX_RESULT));

    // Mode as it stands after this cycle's write
    logic [7:0] mode_nx;
    logic en_nx, hw_nx, pd_nx, halted, abort;
    logic [2:0] fr_nx;
    assign mode_nx = wr_mode ? pwdata[7:0] : mode_q;
    assign en_nx = mode_nx[sas_pkg::SAS_EN_BIT];
    assign hw_nx = mode_nx[sas_pkg::SAS_TRIG_BIT];
    assign pd_nx = mode_nx[sas_pkg::SAS_PD_BIT];
    assign fr_nx = mode_nx[sas_pkg::SAS_FR_LSB +: 3];
    assign halted = standby_idle | standby_stop;
    assign abort = halted | ~en_nx | wr_mode | wr_chan;

    // Edge qualification on the synchronised trigger
    logic rise, fall, trig_edge;
    logic [1:0] edge_sel;
    assign edge_sel = mode_q[sas_pkg::SAS_EDGE_LSB +: 2];
    assign rise = trig_s2_q & ~trig_s3_q;
    assign fall = ~trig_s2_q & trig_s3_q;
    assign trig_edge =
        (rise & (edge_sel == sas_pkg::SAS_EDGE_RISE))
        | (fall & (edge_sel == sas_pkg::SAS_EDGE_FALL))
        | ((rise | fall) & (edge_sel == sas_pkg::SAS_EDGE_BOTH));

    // Decision on the current trial bit
    logic [9:0] sar_decided;
    logic slot_end, done_now;
    assign sar_decided = comp_s2_q ? sar_q : (sar_q & ~trial_mask(bit_q));
    assign slot_end = (cnt_q == 8'h00);
    assign done_now = ~abort & (state_q == sas_pkg::ST_BIT) & slot_end
        & (bit_q == 4'h0);

    // Read mux
    logic [31:0] rd_val;
    logic mapped;
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == reg_addr(sas_pkg::SAS_IDX_MODE1)) begin
            rd_val = {24'h00_0000, mode_q};
        end else if (paddr == reg_addr(sas_pkg::SAS_IDX_CHAN)) begin
            rd_val = {28'h000_0000, chan_q};
        end else if (paddr == reg_addr(sas_pkg::SAS_IDX_RESULT)) begin
            rd_val = {22'h00_0000, result_q};
        end else if (paddr == reg_addr(sas_pkg::SAS_IDX_LADDER)) begin
            rd_val = {31'h0000_0000, ladder_q};
        end else begin
            mapped = 1'b0;
        end
    end

    // APB answer: data latched in setup, ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata_q <= rd_val;
            end
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= sas_pkg::SAS_MODE1_RST;
            chan_q <= sas_pkg::SAS_CHAN_RST;
            ladder_q <= sas_pkg::SAS_LADDER_RST;
        end else begin
            mode_q <= mode_nx;
            if (wr_chan) begin
                chan_q <= pwdata[3:0];
            end
            if (wr_ladder) begin
                ladder_q <= pwdata[sas_pkg::SAS_LADDER_BIT];
            end
        end
    end

    // Trigger and comparator synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end else begin
            trig_s1_q <= ext_trigger_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            comp_s1_q <= comp_above_in;
            comp_s2_q <= comp_s1_q;
        end
    end

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= sas_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
        end else if (halted || !en_nx) begin
            state_q <= sas_pkg::ST_IDLE;
        end else if (wr_mode || wr_chan || state_q == sas_pkg::ST_IDLE
                     || (state_q == sas_pkg::ST_WAIT_TRIG && trig_edge)
                     || done_now) begin
            // Fresh start, or wait for an edge in hardware mode
            if (hw_nx && !(state_q == sas_pkg::ST_WAIT_TRIG && trig_edge
                           && !wr_mode && !wr_chan)) begin
                state_q <= sas_pkg::ST_WAIT_TRIG;
            end else if (pd_nx) begin
                state_q <= sas_pkg::ST_STAB;
                cnt_q <= stab_len(fr_nx) - 8'h01;
            end else begin
                state_q <= sas_pkg::ST_SAMPLE;
                cnt_q <= 8'(slot_len(fr_nx) * 2) - 8'h01;
            end
            sar_q <= 10'h000;
        end else begin
            unique case (state_q)
                sas_pkg::ST_WAIT_TRIG: begin
                    state_q <= sas_pkg::ST_WAIT_TRIG;
                end
                sas_pkg::ST_STAB: begin
                    if (slot_end) begin
                        state_q <= sas_pkg::ST_SAMPLE;
                        cnt_q <= 8'(slot_len(fr_nx) * 2) - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                sas_pkg::ST_SAMPLE: begin
                    if (slot_end) begin
                        state_q <= sas_pkg::ST_BIT;
                        bit_q <= 4'(sas_pkg::SAS_SAR_BITS - 1);
                        sar_q <= sas_pkg::SAS_SAR_MSB;
                        cnt_q <= slot_len(fr_nx) - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                sas_pkg::ST_BIT: begin
                    if (slot_end) begin
                        // Keep or drop, then try the next lower bit
                        sar_q <= sar_decided | trial_mask(bit_q - 4'h1);
                        bit_q <= bit_q - 4'h1;
                        cnt_q <= slot_len(fr_nx) - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= sas_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Result update, deferred one cycle behind a coinciding read
    logic result_we;
    logic [9:0] result_val;
    assign result_we = (done_now & ~rd_result) | (pend_q & ~rd_result);
    assign result_val = pend_q ? pend_val_q : sar_decided;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= sas_pkg::SAS_RESULT_RST;
            pend_q <= 1'b0;
            pend_val_q <= 10'h000;
            irq_q <= 1'b0;
        end else begin
            irq_q <= result_we;
            if (result_we) begin
                result_q <= result_val;
            end
            if (done_now) begin
                pend_val_q <= sar_decided;
            end
            pend_q <= rd_result & (done_now | pend_q);
        end
    end

    // Analog side controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_q <= 1'b0;
            sh_q <= 1'b0;
        end else begin
            pd_q <= mode_q[sas_pkg::SAS_PD_BIT] & ~mode_q[sas_pkg::SAS_EN_BIT];
            sh_q <= (state_q == sas_pkg::ST_SAMPLE);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analog_sel = chan_q;
    assign ladder_connect = ladder_q;
    assign comparator_power_down = pd_q;
    assign sample_hold = sh_q;
    assign ladder_tap = sar_q;
    assign conv_done_irq = irq_q;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chan_write_a:
    assert property (wr_chan |=> analog_sel == $past(pwdata[3:0]))
        else $error("channel select not taken");
    reset_regs_a:
    assert property ($rose(presetn) |-> analog_sel == 4'h0 && !ladder_connect)
        else $error("registers not zero after reset");
    ladder_bit_a:
    assert property (wr_ladder |=> ladder_connect == $past(pwdata[0]))
        else $error("ladder connect not taken");
    msb_trial_a:
    assert property ((state_q == sas_pkg::ST_BIT
                      && $past(state_q) == sas_pkg::ST_SAMPLE)
                     |-> ladder_tap == 10'h200)
        else $error("first trial is not bit 9");
    step_down_a:
    assert property ((state_q == sas_pkg::ST_BIT && slot_end && !abort
                      && bit_q != 4'h0) |=> bit_q == $past(bit_q) - 4'h1)
        else $error("approximation did not step down");
    done_irq_a:
    assert property (done_now && !rd_result
                     |=> conv_done_irq && result_q == $past(sar_decided))
        else $error("result and done not together");
    result_reset_a:
    assert property ($rose(presetn) |-> result_q == 10'h000)
        else $error("result not cleared by reset");
    trig_start_a:
    assert property (state_q == sas_pkg::ST_WAIT_TRIG && trig_edge && !abort
                     |=> state_q inside {sas_pkg::ST_STAB, sas_pkg::ST_SAMPLE})
        else $error("trigger edge did not start");
    hw_rewait_a:
    assert property (done_now && mode_q[sas_pkg::SAS_TRIG_BIT]
                     |=> state_q == sas_pkg::ST_WAIT_TRIG [*2])
        else $error("hardware mode restarted without edge");
    stop_now_a:
    assert property (wr_mode && !pwdata[sas_pkg::SAS_EN_BIT]
                     |=> state_q == sas_pkg::ST_IDLE)
        else $error("enable clear did not stop");
    sw_repeat_a:
    assert property (done_now && !mode_q[sas_pkg::SAS_TRIG_BIT]
                     |=> state_q inside {sas_pkg::ST_STAB, sas_pkg::ST_SAMPLE})
        else $error("software mode did not repeat");
    halt_stop_a:
    assert property (halted |=> state_q == sas_pkg::ST_IDLE)
        else $error("conversion ran in standby");
    read_wins_a:
    assert property (done_now && rd_result && !penable ##1 !rd_result
                     |=> result_q == $past(sar_decided, 2))
        else $error("deferred result not written");

    sw_done_c: cover property (done_now && !mode_q[sas_pkg::SAS_TRIG_BIT]);
    hw_done_c: cover property (done_now && mode_q[sas_pkg::SAS_TRIG_BIT]);
    abort_c: cover property (state_q == sas_pkg::ST_BIT && wr_chan);
    clash_c: cover property (done_now && rd_result);

endmodule : sas_sequencer

// File: sas_pkg.sv
// Constants, field positions and state type of the converter sequencer.
// Assumes pclk also serves as the converter clock for all cycle figures.
package sas_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [31:0] SAS_IDX_MODE1 = 32'hfffff3c0;
    localparam logic [31:0] SAS_IDX_CHAN = 32'hfffff3c2;
    localparam logic [31:0] SAS_IDX_RESULT = 32'hfffff3c4;
    localparam logic [31:0] SAS_IDX_LADDER = 32'hfffff3c8;

    // Mode register one fields
    localparam int SAS_EN_BIT = 7;
    localparam int SAS_TRIG_BIT = 6;
    localparam int SAS_FR_LSB = 3;
    localparam int SAS_EDGE_LSB = 1;
    localparam int SAS_PD_BIT = 0;
    // Ladder supply connect field
    localparam int SAS_LADDER_BIT = 0;

    // Reset values
    localparam logic [7:0] SAS_MODE1_RST = 8'h00;
    localparam logic [3:0] SAS_CHAN_RST = 4'h0;
    localparam logic SAS_LADDER_RST = 1'b0;
    localparam logic [9:0] SAS_RESULT_RST = 10'h000;

    // Edge select encodings
    localparam logic [1:0] SAS_EDGE_NONE = 2'b00;
    localparam logic [1:0] SAS_EDGE_FALL = 2'b01;
    localparam logic [1:0] SAS_EDGE_RISE = 2'b10;
    localparam logic [1:0] SAS_EDGE_BOTH = 2'b11;

    // Approximation layout
    localparam int SAS_SAR_BITS = 10;
    localparam logic [9:0] SAS_SAR_MSB = 10'h200;
    localparam int SAS_SLOTS = 12;
    localparam int SAS_SAMPLE_SLOTS = 2;

    // Conversion and stabilisation cycles per rate code
    localparam int SAS_CONV_FR0 = 168;
    localparam int SAS_CONV_FR1 = 120;
    localparam int SAS_CONV_FR2 = 84;
    localparam int SAS_CONV_FR3 = 60;
    localparam int SAS_CONV_FR4 = 48;
    localparam int SAS_CONV_FR5 = 36;
    localparam int SAS_CONV_FR7 = 12;
    localparam int SAS_STAB_FR0 = 64;
    localparam int SAS_STAB_FR1 = 60;
    localparam int SAS_STAB_FR2 = 42;
    localparam int SAS_STAB_FR3 = 30;
    localparam int SAS_STAB_FR4 = 24;
    localparam int SAS_STAB_FR5 = 18;
    localparam int SAS_STAB_FR7 = 6;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_STAB,
        ST_SAMPLE,
        ST_BIT
    } sas_state_t;

endpackage : sas_pkg

// File: sas_analog_model.sv
// Behavioural analog side: input levels, sample-and-hold and comparator.
// Assumes levels in half steps of the reference, 0 to 2047 per input.
`timescale 1ns/1ps

module sas_analog_model (
    input wire logic pclk, // Converter clock
    input wire logic [11:0][10:0] levels, // Input levels, half steps
    input wire logic [3:0] analog_sel, // Selected input
    input wire logic sample_hold, // Tracking while high
    input wire logic [9:0] ladder_tap, // Trial code on the ladder
    input wire logic ladder_connect, // Ladder supplied
    input wire logic comparator_power_down, // Comparator off
    output logic comp_above_in // Input at or above tap
);
    logic [10:0] held;
    logic junk = 1'b0;

    // Track while sampling, freeze once the hold begins
    always @* begin
        if (sample_hold) begin
            held = levels[analog_sel];
        end
    end

    // Meaningless answer source for an unpowered comparator
    always @(posedge pclk) begin
        junk <= ~junk;
    end

    // Threshold half a step below the trial code
    always @* begin
        if (comparator_power_down || !ladder_connect) begin
            comp_above_in = junk;
        end else begin
            comp_above_in = ({1'b0, held} + 12'h001) >=
                {1'b0, ladder_tap, 1'b0};
        end
    end
endmodule : sas_analog_model

// File: tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer with analog model.
// Assumes APB slave answers without wait states, rate code 4 throughout.
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) begin \
            num_errors++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
        end \
    end

module tb_sar_adc_sequencer;
    localparam logic [31:0] A_MODE = {sas_pkg::SAS_IDX_MODE1[29:0], 2'b00};
    localparam logic [31:0] A_CHAN = {sas_pkg::SAS_IDX_CHAN[29:0], 2'b00};
    localparam logic [31:0] A_RES = {sas_pkg::SAS_IDX_RESULT[29:0], 2'b00};
    localparam logic [31:0] A_LAD = {sas_pkg::SAS_IDX_LADDER[29:0], 2'b00};
    localparam logic [31:0] A_BAD = 32'hffffcf04;
    localparam int SLOT = sas_pkg::SAS_CONV_FR4 / sas_pkg::SAS_SLOTS;
    localparam int STAB = sas_pkg::SAS_STAB_FR4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic ext_trigger_in, comp_above_in, standby_idle, standby_stop;
    logic ladder_connect, comparator_power_down, sample_hold, conv_done_irq;
    logic [3:0] analog_sel;
    logic [9:0] ladder_tap;
    logic [11:0][10:0] levels;
    int num_errors = 0;
    int checks_done = 0;
    int irq_cnt = 0;
    int cyc = 0;
    int last_irq = 0;
    int gap = 0;

    sas_sequencer DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trigger_in(ext_trigger_in), .comp_above_in(comp_above_in),
        .standby_idle(standby_idle), .standby_stop(standby_stop),
        .analog_sel(analog_sel), .ladder_connect(ladder_connect),
        .comparator_power_down(comparator_power_down),
        .sample_hold(sample_hold), .ladder_tap(ladder_tap),
        .conv_done_irq(conv_done_irq));

    sas_analog_model analog (.pclk(pclk), .levels(levels),
        .analog_sel(analog_sel), .sample_hold(sample_hold),
        .ladder_tap(ladder_tap), .ladder_connect(ladder_connect),
        .comparator_power_down(comparator_power_down),
        .comp_above_in(comp_above_in));

    // Clock at 200 MHz
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Count done pulses and the spacing between them
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (conv_done_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            gap <= cyc - last_irq;
            last_irq <= cyc;
        end
    end

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) num_errors++;
    endtask : apb

    // Wait for the next done pulse, bounded
    task automatic wait_irq(input int lim, output int t);
        int c0;
        c0 = irq_cnt;
        t = 0;
        while (irq_cnt == c0 && t < lim) begin
            @(posedge pclk);
            t++;
        end
    endtask : wait_irq

    // Mode register value at rate code 4
    function automatic logic [31:0] mode(input logic en, input logic hw,
            input logic [1:0] eg, input logic pd);
        return {24'h000000, en, hw, 3'h4, eg, pd};
    endfunction : mode

    // Code expected from a level given in half steps
    function automatic logic [9:0] exp_code(input logic [10:0] v);
        logic [11:0] s;
        s = ({1'b0, v} + 12'h001) >> 1;
        return (s > 12'h3ff) ? 10'h3ff : s[9:0];
    endfunction : exp_code

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [31:0] regs [4];
        logic [3:0] ch;
        int t;
        int c;
        regs = '{A_MODE, A_CHAN, A_LAD, A_RES};
        {presetn, psel, penable, pwrite, ext_trigger_in} = 5'h00;
        {standby_idle, standby_stop, paddr, pwdata} = '0;
        void'($urandom(14));
        for (int i = 0; i < 12; i++) levels[i] = 11'($urandom_range(2047, 0));
        levels[0] = 11'h000;
        levels[1] = 11'h3ff;
        levels[11] = 11'h7ff;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, regs[i], 32'h0);
            `CHK("reset value", 32'h0, rd);
        end
        apb(1'b1, A_BAD, 32'hffffffff);
        apb(1'b0, A_BAD, 32'h0);
        `CHK("unmapped", 33'h000000000, {~err, rd});
        apb(1'b1, A_CHAN, 32'h00000005);
        apb(1'b0, A_CHAN, 32'h0);
        `CHK("channel", 32'h5, rd);
        `CHK("analog_sel", 4'h5, analog_sel);
        apb(1'b1, A_LAD, 32'h1);
        apb(1'b0, A_LAD, 32'h0);
        `CHK("ladder", 33'h100000001, {ladder_connect, rd});
        apb(1'b1, A_MODE, mode(1'b0, 1'b0, 2'h0, 1'b1));
        repeat (2) @(posedge pclk);
        `CHK("power down", 1'b1, comparator_power_down);
        apb(1'b1, A_MODE, 32'h0);
        repeat (1000) @(posedge pclk);
        // Continuous software conversions, corners then random
        for (int k = 0; k < 6; k++) begin
            ch = (k == 0) ? 4'h0 : (k == 1) ? 4'hb : (k == 2) ? 4'h1 :
                4'($urandom_range(11, 0));
            apb(1'b1, A_CHAN, {28'h0, ch});
            apb(1'b1, A_MODE, mode(1'b1, 1'b0, 2'h0, 1'b0));
            wait_irq(200, t);
            `CHK("restart", 1'b1, t >= 12 * SLOT && t < 200);
            wait_irq(200, t);
            `CHK("gap", 1'b1, gap >= 12 * SLOT && gap <= 12 * SLOT + 3);
            apb(1'b0, A_RES, 32'h0);
            `CHK("result", {22'h0, exp_code(levels[ch])}, rd);
        end
        // Stabilisation phase lengthens each repeated conversion
        apb(1'b1, A_MODE, mode(1'b1, 1'b0, 2'h0, 1'b1));
        wait_irq(200, t);
        wait_irq(200, t);
        `CHK("stab gap", 12 * SLOT + STAB, gap);
        apb(1'b1, A_MODE, 32'h0);
        repeat (2) @(posedge pclk);
        c = irq_cnt;
        repeat (150) @(posedge pclk);
        `CHK("stopped", c, irq_cnt);
        // Standby idle then stop halts the converter
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, A_MODE, mode(1'b1, 1'b0, 2'h0, 1'b0));
            standby_idle <= (s == 0);
            standby_stop <= (s == 1);
            @(posedge pclk);
            c = irq_cnt;
            repeat (150) @(posedge pclk);
            `CHK("standby", c, irq_cnt);
            standby_idle <= 1'b0;
            standby_stop <= 1'b0;
            wait_irq(200, t);
            `CHK("resume", 1'b1, t < 200);
        end
        // Hardware trigger response for every edge code, none for code 0
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, A_MODE, mode(1'b1, 1'b1, 2'(e), 1'b0));
            c = irq_cnt;
            repeat (80) @(posedge pclk);
            `CHK("hw wait", c, irq_cnt);
            ext_trigger_in <= 1'b1;
            repeat (160) @(posedge pclk);
            c += (e >> 1) & 1;
            `CHK("rise", c, irq_cnt);
            ext_trigger_in <= 1'b0;
            repeat (160) @(posedge pclk);
            c += e & 1;
            `CHK("fall", c, irq_cnt);
        end
        ext_trigger_in <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b1, A_MODE, mode(1'b1, 1'b1, 2'h3, 1'b0));
        c = irq_cnt;
        repeat (160) @(posedge pclk);
        `CHK("hw abort", c, irq_cnt);
        ext_trigger_in <= 1'b0;
        repeat (160) @(posedge pclk);
        `CHK("hw rerun", c + 1, irq_cnt);
        apb(1'b1, A_MODE, mode(1'b0, 1'b0, 2'h0, 1'b1));
        apb(1'b1, A_LAD, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("unused", 2'h1, {ladder_connect, comparator_power_down});
        stop_test();
    end
endmodule : tb_sar_adc_sequencer
